// >>> rtl/eir_pkg.sv
// constants for the maskable interrupt request block
package eir_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TFLG = 8'h04;
    localparam logic [7:0] ADDR_TCTL = 8'h08;
    localparam logic [7:0] ADDR_HSK = 8'h0c;
    localparam logic [7:0] ADDR_SSTAT = 8'h10;
    localparam logic [7:0] ADDR_SDATA = 8'h14;
    localparam logic [7:0] ADDR_PINS = 8'h18;
    // ctrl fields
    localparam int CTRL_EDGE = 0;
    localparam int CTRL_OPEN = 1;
    // timer control fields: enables low, capture edge choice above
    localparam int TCTL_EN_LO = 0;
    localparam int TCTL_POL_LO = 4;
    // handshake and serial status fields
    localparam int HSK_FLAG = 0;
    localparam int HSK_EN = 1;
    localparam int SST_FULL = 0;
    localparam int SST_IE = 1;
    // synchroniser lanes
    localparam int SB_IRQ = 0;
    localparam int SB_CAP = 1;
    localparam int SB_STRA = 4;
    localparam int SB_NMI = 5;
    localparam int SYNC_W = 6;
    // pins idle high
    localparam logic [5:0] SYNC_RST = 6'h3f;
    // protected write window in bus clock cycles
    localparam int PROT_CYCLES = 64;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// >>> rtl/eir_request.sv
// maskable interrupt request logic with apb register access
// How it works
// - edge select 0 level, 1 falling edge
// - edge select written once, first 64 cycles
// - reset clears edge select to level mode
// - event sets flag; flag and enable request
// - edge mode latches falling edge, no source
// - line already low hides new edges
// - each peripheral source has flag and enable
// - cpu mask blocks all maskable requests
// - timer flags clear by writing one
// - status read then data read clears rx
// - clear-memory read counts as data read
// - handshake and pin share one vector
// - expanded mode gives handshake to bus
// - capture pins edge interrupts, own edges
// - strobe pin interrupts in single-chip only
// - nonmaskable pin ignores the cpu mask
// - masked requests stay pending until unmasked
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module eir_request
    import eir_pkg::*;
#(
    parameter int NCAP = 3
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic irq_n,
    input wire logic [NCAP-1:0] capture_inputs,
    input wire logic strobe_a_input,
    input wire logic nonmaskable_int_n,
    // cpu side
    input wire logic cpu_mask,
    input wire logic irq_ack,
    input wire logic expanded_mode,
    // serial receiver events
    input wire logic rx_event,
    input wire logic [7:0] rx_data,
    // requests to the sequencer
    output logic irq_vec_req,
    output logic [NCAP-1:0] capture_req,
    output logic serial_req,
    output logic nmi_req,
    // expansion bus handover
    output logic hs_pins_to_bus,
    output logic ext_access
);

    ////////////////////////////////////////////////////////////////
    // helpers shared by every edge detector
    function automatic logic [SYNC_W-1:0] fell(input logic [SYNC_W-1:0] o,
                                               input logic [SYNC_W-1:0] n);
        return o & ~n;
    endfunction

    function automatic logic [SYNC_W-1:0] rose(input logic [SYNC_W-1:0] o,
                                               input logic [SYNC_W-1:0] n);
        return ~o & n;
    endfunction

    ////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, filtered level rises when 2 and 3 are both high, falls when they differ
    logic [SYNC_W-1:0] s1, s2, s3, filt, filt_d;
    logic [SYNC_W-1:0] pins, next_filt;

    assign pins = {nonmaskable_int_n, strobe_a_input, capture_inputs, irq_n};

    always_comb begin
        next_filt = (s2 & s3) | (filt & ~(s2 ^ s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= SYNC_RST;
            s2 <= SYNC_RST;
            s3 <= SYNC_RST;
            filt <= SYNC_RST;
            filt_d <= SYNC_RST;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            filt_d <= filt;
        end
    end

    logic [SYNC_W-1:0] fall_ev, rise_ev;
    assign fall_ev = fell(filt_d, filt);
    assign rise_ev = rose(filt_d, filt);

    ////////////////////////////////////////////////////////////////
    // apb decode; access phase is where side effects happen
    logic wr, rd, setup;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign setup = psel & ~penable;

    // no wait states
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////
    // register state
    logic edge_sel, next_edge_sel;
    logic edge_locked, next_edge_locked;
    logic [6:0] win_cnt, next_win_cnt;
    logic edge_latch, next_edge_latch;
    logic [NCAP-1:0] tflag, next_tflag;
    logic [NCAP-1:0] tien, next_tien;
    logic [NCAP-1:0] cap_pol, next_cap_pol;
    logic hs_flag, next_hs_flag;
    logic hs_en, next_hs_en;
    logic rx_full, next_rx_full;
    logic rx_ie, next_rx_ie;
    logic rx_armed, next_rx_armed;
    logic [7:0] rx_buf, next_rx_buf;
    logic [31:0] next_prdata;
    logic slverr_q, next_slverr_q;
    logic window_open, hs_hit;
    logic [NCAP-1:0] cap_ev;

    assign window_open = (win_cnt < 7'(PROT_CYCLES));
    // handshake addresses go off-chip in expanded mode
    assign hs_hit = (paddr == ADDR_HSK) & expanded_mode;
    assign cap_ev = (cap_pol & fall_ev[SB_CAP +: NCAP])
                  | (~cap_pol & rise_ev[SB_CAP +: NCAP]);

    // next state for all software-visible state
    always_comb begin
        next_edge_sel = edge_sel;
        next_edge_locked = edge_locked;
        next_win_cnt = window_open ? win_cnt + 7'd1 : win_cnt;
        next_edge_latch = edge_latch;
        next_tflag = tflag;
        next_tien = tien;
        next_cap_pol = cap_pol;
        next_hs_flag = hs_flag;
        next_hs_en = hs_en;
        next_rx_full = rx_full;
        next_rx_ie = rx_ie;
        next_rx_armed = rx_armed;
        next_rx_buf = rx_buf;
        next_prdata = prdata;
        next_slverr_q = slverr_q;

        // write-once edge select inside the protected window
        if (wr && paddr == ADDR_CTRL && window_open && !edge_locked) begin
            next_edge_sel = pwdata[CTRL_EDGE];
            next_edge_locked = 1'b1;
        end
        if (wr && paddr == ADDR_TCTL) begin
            next_tien = pwdata[TCTL_EN_LO +: NCAP];
            next_cap_pol = pwdata[TCTL_POL_LO +: NCAP];
        end
        if (wr && paddr == ADDR_HSK && !expanded_mode) begin
            next_hs_en = pwdata[HSK_EN];
        end
        if (wr && paddr == ADDR_SSTAT) begin
            next_rx_ie = pwdata[SST_IE];
        end

        // clears first, so events below win over them
        if (irq_ack) begin
            next_edge_latch = 1'b0;
        end
        if (wr && paddr == ADDR_TFLG) begin
            next_tflag = tflag & ~pwdata[NCAP-1:0];
        end
        if (wr && paddr == ADDR_HSK && !expanded_mode && pwdata[HSK_FLAG]) begin
            next_hs_flag = 1'b0;
        end
        // status read with flag set arms; data read then clears.
        // a write cycle never reads, so a clear-memory must show as apb read
        if (rd && paddr == ADDR_SSTAT && rx_full) begin
            next_rx_armed = 1'b1;
        end
        if (rd && paddr == ADDR_SDATA && rx_armed) begin
            next_rx_full = 1'b0;
            next_rx_armed = 1'b0;
        end

        // hardware events
        if (edge_sel && fall_ev[SB_IRQ]) begin
            next_edge_latch = 1'b1;
        end
        next_tflag = next_tflag | cap_ev;
        if (!expanded_mode && fall_ev[SB_STRA]) begin
            next_hs_flag = 1'b1;
        end
        if (rx_event) begin
            next_rx_full = 1'b1;
            next_rx_armed = 1'b0;
            next_rx_buf = rx_data;
        end

        // read data captured in setup so it comes from a flip-flop
        if (setup) begin
            next_slverr_q = 1'b0;
            next_prdata = RD_ZERO;
            case (paddr)
                ADDR_CTRL: begin
                    next_prdata[CTRL_EDGE] = edge_sel;
                    next_prdata[CTRL_OPEN] = window_open & ~edge_locked;
                end
                ADDR_TFLG: next_prdata[NCAP-1:0] = tflag;
                ADDR_TCTL: begin
                    next_prdata[TCTL_EN_LO +: NCAP] = tien;
                    next_prdata[TCTL_POL_LO +: NCAP] = cap_pol;
                end
                ADDR_HSK: begin
                    if (!expanded_mode) begin
                        next_prdata[HSK_FLAG] = hs_flag;
                        next_prdata[HSK_EN] = hs_en;
                    end
                end
                ADDR_SSTAT: begin
                    next_prdata[SST_FULL] = rx_full;
                    next_prdata[SST_IE] = rx_ie;
                end
                ADDR_SDATA: next_prdata[7:0] = rx_buf;
                ADDR_PINS: next_prdata[SYNC_W-1:0] = filt;
                default: next_slverr_q = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel <= 1'b0;
            edge_locked <= 1'b0;
            win_cnt <= 7'd0;
            edge_latch <= 1'b0;
            tflag <= '0;
            tien <= '0;
            cap_pol <= '0;
            hs_flag <= 1'b0;
            hs_en <= 1'b0;
            rx_full <= 1'b0;
            rx_ie <= 1'b0;
            rx_armed <= 1'b0;
            rx_buf <= 8'h00;
            prdata <= RD_ZERO;
            slverr_q <= 1'b0;
        end else begin
            edge_sel <= next_edge_sel;
            edge_locked <= next_edge_locked;
            win_cnt <= next_win_cnt;
            edge_latch <= next_edge_latch;
            tflag <= next_tflag;
            tien <= next_tien;
            cap_pol <= next_cap_pol;
            hs_flag <= next_hs_flag;
            hs_en <= next_hs_en;
            rx_full <= next_rx_full;
            rx_ie <= next_rx_ie;
            rx_armed <= next_rx_armed;
            rx_buf <= next_rx_buf;
            prdata <= next_prdata;
            slverr_q <= next_slverr_q;
        end
    end

    assign pslverr = psel & penable & slverr_q;

    ////////////////////////////////////////////////////////////////
    // request outputs; pending state stays while masked
    logic ext_pend, hs_req;
    assign ext_pend = edge_sel ? edge_latch : ~filt[SB_IRQ];
    assign hs_req = hs_flag & hs_en & ~expanded_mode;
    assign irq_vec_req = (ext_pend | hs_req) & ~cpu_mask;
    assign capture_req = tflag & tien & {NCAP{~cpu_mask}};
    assign serial_req = rx_full & rx_ie & ~cpu_mask;
    assign nmi_req = ~filt[SB_NMI];
    assign hs_pins_to_bus = expanded_mode;
    assign ext_access = psel & hs_hit;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_edge_latch;
        edge_sel && fall_ev[SB_IRQ] |=> edge_latch;
    endproperty
    a_edge_latch: assert property (p_edge_latch) else $error("edge not latched");
    property p_level_req;
        !edge_sel && !filt[SB_IRQ] && !cpu_mask |-> irq_vec_req;
    endproperty
    a_level_req: assert property (p_level_req) else $error("low level not requested");
    property p_once;
        edge_locked |=> $stable(edge_sel);
    endproperty
    a_once: assert property (p_once) else $error("edge select changed twice");
    property p_late;
        !window_open |=> $stable(edge_sel) && $stable(edge_locked);
    endproperty
    a_late: assert property (p_late) else $error("write after window took");
    property p_reset_level;
        $rose(win_cnt == 7'd1) |-> !edge_sel;
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("edge select not cleared");
    property p_mask;
        cpu_mask |-> !irq_vec_req && capture_req == '0 && !serial_req;
    endproperty
    a_mask: assert property (p_mask) else $error("masked request leaked");
    property p_w1c;
        wr && paddr == ADDR_TFLG && tflag[0] && !pwdata[0] |=> tflag[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("timer flag lost on zero write");

    property p_rx_clear;
        rd && paddr == ADDR_SDATA && rx_armed && !rx_event |=> !rx_full;
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx flag not cleared");

    property p_nmi;
        cpu_mask && !s2[SB_NMI] && !s3[SB_NMI] |=> nmi_req;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi blocked by mask");

    property p_strobe;
        expanded_mode && fall_ev[SB_STRA] && !hs_flag |=> !hs_flag;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe set in expanded mode");

endmodule

// >>> bench/eir_ext_src.sv
// model of the external sources sharing the wired-or request line
`timescale 1ns/1ns
module eir_ext_src (
    // request levels of the two sources
    input wire logic src_a,
    input wire logic src_b,
    // shared request line
    output logic irq_line
);
    ////////////////////////////////////////////////////////////////////
    // each source pulls low while it asks, the pull-up wins otherwise
    assign irq_line = (src_a | src_b) ? 1'b0 : 1'b1;
endmodule

// >>> bench/external_and_peripheral_int_request_tb_top.sv
// self-checking bench for the maskable interrupt request block
`timescale 1ns/1ns
module external_and_peripheral_int_request_tb_top;
    import eir_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, rx_data;
    logic [31:0] pwdata, prdata, rd;
    logic irq_n, strobe_a_input, nonmaskable_int_n, cpu_mask, irq_ack;
    logic expanded_mode, rx_event, src_a, src_b, serial_req, nmi_req;
    logic [2:0] capture_inputs, capture_req;
    logic irq_vec_req, hs_pins_to_bus, ext_access, xa;
    int error_cnt, checked;
    ////////////////////////////////////////////////////////////////////
    eir_request #(.NCAP(3)) eir_request_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_n(irq_n), .capture_inputs(capture_inputs),
        .strobe_a_input(strobe_a_input), .nonmaskable_int_n(nonmaskable_int_n),
        .cpu_mask(cpu_mask), .irq_ack(irq_ack), .expanded_mode(expanded_mode),
        .rx_event(rx_event), .rx_data(rx_data), .irq_vec_req(irq_vec_req),
        .capture_req(capture_req), .serial_req(serial_req), .nmi_req(nmi_req),
        .hs_pins_to_bus(hs_pins_to_bus), .ext_access(ext_access));
    eir_ext_src eir_ext_src_i (.src_a(src_a), .src_b(src_b), .irq_line(irq_n));
    // 50 ns clock
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            error_cnt++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        xa = ext_access;
        psel <= 0; penable <= 0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_level;
        apb(0, ADDR_CTRL, 0);
        chk("ctrl reset", 32'h0000_0002, rd);
        src_a <= 1;
        cyc(2);
        chk("irq early", 0, irq_vec_req);
        cyc(8);
        chk("irq level", 1, irq_vec_req);
        src_a <= 0;
        cyc(8);
        chk("irq released", 0, irq_vec_req);
        $display("level test done");
    endtask
    task automatic ack;
        @(posedge pclk) irq_ack <= 1;
        @(posedge pclk) irq_ack <= 0;
        cyc(2);
    endtask
    task automatic t_edge;
        apb(1, ADDR_CTRL, 1);
        apb(1, ADDR_CTRL, 0);
        apb(0, ADDR_CTRL, 0);
        chk("ctrl once", 32'h0000_0001, rd);
        src_a <= 1;
        cyc(8);
        src_a <= 0;
        cyc(8);
        chk("edge latch", 1, irq_vec_req);
        ack();
        chk("edge acked", 0, irq_vec_req);
        src_b <= 1;
        cyc(8);
        ack();
        src_a <= 1;
        cyc(8);
        chk("hidden edge", 0, irq_vec_req);
        src_a <= 0; src_b <= 0;
        cyc(8);
        $display("edge test done");
    endtask
    task automatic t_cap;
        apb(1, ADDR_TCTL, 32'h0000_0011);
        cpu_mask <= 1; capture_inputs <= 3'b110;
        cyc(8);
        apb(0, ADDR_TFLG, 0);
        chk("cap flag", 1, rd);
        chk("cap masked", 0, capture_req);
        cpu_mask <= 0;
        cyc(2);
        chk("cap pending", 3'b001, capture_req);
        apb(1, ADDR_TFLG, 0);
        apb(0, ADDR_TFLG, 0);
        chk("flag kept", 1, rd);
        apb(1, ADDR_TFLG, 1);
        apb(0, ADDR_TFLG, 0);
        chk("flag cleared", 0, rd);
        chk("cap req off", 0, capture_req);
        capture_inputs <= 3'b111;
        $display("capture test done");
    endtask
    task automatic t_serial;
        apb(1, ADDR_SSTAT, 2);
        @(posedge pclk) rx_event <= 1;
        rx_data <= 8'ha5;
        @(posedge pclk) rx_event <= 0;
        cyc(2);
        chk("ser req", 1, serial_req);
        apb(0, ADDR_SDATA, 0);
        chk("ser data", 8'ha5, rd);
        chk("ser kept", 1, serial_req);
        apb(0, ADDR_SSTAT, 0);
        chk("ser stat", 3, rd);
        apb(0, ADDR_SDATA, 0);
        cyc(2);
        chk("ser clr", 0, serial_req);
        $display("serial test done");
    endtask
    task automatic t_hsk;
        apb(1, ADDR_HSK, 2);
        strobe_a_input <= 0;
        cyc(8);
        chk("hs vec", 1, irq_vec_req);
        apb(0, ADDR_HSK, 0);
        chk("hs flag", 3, rd);
        chk("hs int access", 0, xa);
        apb(1, ADDR_HSK, 3);
        strobe_a_input <= 1; expanded_mode <= 1;
        cyc(8);
        chk("hs bus", 1, hs_pins_to_bus);
        strobe_a_input <= 0;
        cyc(8);
        chk("hs exp", 0, irq_vec_req);
        apb(0, ADDR_HSK, 0);
        chk("hs ext rd", 0, rd);
        chk("hs ext err", 0, err);
        chk("hs ext access", 1, xa);
        apb(0, 8'h1c, 0);
        chk("unmapped", 1, err);
        strobe_a_input <= 1; expanded_mode <= 0; cpu_mask <= 1;
        nonmaskable_int_n <= 0;
        cyc(8);
        chk("nmi", 1, nmi_req);
        apb(0, ADDR_HSK, 0);
        chk("hs no late set", 2, rd);
        apb(0, ADDR_PINS, 0);
        chk("pins", 32'h0000_001f, rd);
        nonmaskable_int_n <= 1; cpu_mask <= 0;
        $display("handshake test done");
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence; ctrl window needs the edge test early
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        src_a = 0; src_b = 0; capture_inputs = 3'b111; strobe_a_input = 1;
        nonmaskable_int_n = 1; cpu_mask = 0; irq_ack = 0; expanded_mode = 0;
        rx_event = 0; rx_data = 0; error_cnt = 0; checked = 0;
        cyc(20);
        presetn <= 1;
        t_level();
        t_edge();
        t_cap();
        t_serial();
        t_hsk();
        finish_test();
    end
    // hang guard
    initial begin
        cyc(20000);
        error_cnt++;
        finish_test();
    end
endmodule
